/* File: design/sbm_cmd_map.sv */
// sbm_cmd_map: two-wire slave command map plus word-write master
// that pushes charging requests. Pins are open drain; the
// surrounding pad ties each pin low while its _oe is high.
module sbm_cmd_map #(
  parameter logic [6:0]  SLAVE_ADDR  = 7'h0b,
  parameter logic [6:0]  CHARGE_ADDR = 7'h09,
  parameter logic [15:0] FW_VERSION  = 16'h0001, // arbitrary value
  parameter logic [15:0] SPEC_INFO   = 16'h0011, // arbitrary value
  parameter logic [15:0] PW_FIRST    = 16'h1234,
  parameter logic [15:0] PW_SECOND   = 16'h5678,
  parameter logic [31:0] TXT_MAKER   = 32'h41424344, // arbitrary value
  parameter logic [31:0] TXT_PROD    = 32'h50414b31, // arbitrary value
  parameter logic [31:0] TXT_CHEM    = 32'h4e694d48,
  parameter logic [31:0] MAKER_DATA  = 32'h00000000,
  parameter logic        HAS_INT_CHG = 1'b0,
  parameter logic        HAS_PRI_SUP = 1'b0
) (
  input  wire logic              clock,
  input  wire logic              srst,
  input  wire logic              scl_i,
  input  wire logic              sda_i,
  input  wire sbm_pkg::sbm_meas_t meas,
  input  wire logic              charge_push,
  output logic                   scl_o_q,
  output logic                   scl_oe_q,
  output logic                   sda_o_q,
  output logic                   sda_oe_q,
  output logic [15:0]            mode_q,
  output logic [15:0]            rate_q,
  output logic [15:0]            cap_alarm_q,
  output logic [15:0]            time_alarm_q,
  output logic                   unlock_q
);
  import sbm_pkg::*;

  if (QTR_CYC < 2 || QTR_CYC > 511) begin : g_bad_div
    $error("sbm_cmd_map: quarter bit count out of range");
  end
  if (SLAVE_ADDR == CHARGE_ADDR) begin : g_bad_addr
    $error("sbm_cmd_map: own address equals charger address");
  end

  typedef enum logic [1:0] {SL_IDLE, SL_RX, SL_TX, SL_WAIT} sbm_sl_t;
  typedef enum logic [1:0] {M_IDLE, M_START, M_BIT, M_STOP} sbm_ms_t;

  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  function automatic logic mapped(input logic [7:0] c);
    return (c <= CMD_FW_INFO) || (c >= CMD_TXT_MAKER && c <= CMD_MAKER_DAT)
        || (c == CMD_PIN_STATE) || (c >= CMD_VEND_LO && c <= CMD_VEND_HI);
  endfunction

  // byte k of a read answer; text codes answer as blocks
  function automatic logic [7:0] tx_byte(input logic [7:0] c, input logic [2:0] k,
      input logic [7:0] crc, input logic [15:0] w, input logic [31:0] t);
    logic blk;
    blk = (c >= CMD_TXT_MAKER && c <= CMD_MAKER_DAT);
    if (blk) begin
      unique case (k)
        3'h0:    return TEXT_LEN;
        3'h1:    return t[31:24];
        3'h2:    return t[23:16];
        3'h3:    return t[15:8];
        3'h4:    return t[7:0];
        3'h5:    return crc;
        default: return FILL_BYTE;
      endcase
    end
    unique case (k)
      3'h0:    return w[7:0];
      3'h1:    return w[15:8];
      3'h2:    return crc;
      default: return FILL_BYTE;
    endcase
  endfunction

  // pin synchronisers: stage 0 feeds stage 1 only
  logic [2:0] scl_s_q, scl_s_d, sda_s_q, sda_s_d;
  logic       scl, sda, scl_rise, scl_fall, start, stop;

  always_comb begin
    scl_s_d = {scl_s_q[1:0], scl_i};
    sda_s_d = {sda_s_q[1:0], sda_i};
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      scl_s_q <= 3'h7;
      sda_s_q <= 3'h7;
    end else begin
      scl_s_q <= scl_s_d;
      sda_s_q <= sda_s_d;
    end
  end

  assign scl      = scl_s_q[1];
  assign sda      = sda_s_q[1];
  assign scl_rise = scl & ~scl_s_q[2];
  assign scl_fall = ~scl & scl_s_q[2];
  assign start    = scl & scl_s_q[2] & ~sda & sda_s_q[2];
  assign stop     = scl & scl_s_q[2] & sda & ~sda_s_q[2];

  // slave engine and register file
  sbm_sl_t     sst_q, sst_d;
  logic [3:0]  bit_q, bit_d;
  logic [2:0]  idx_q, idx_d, tix_q, tix_d, tn;
  logic [7:0]  sh_q, sh_d, tsh_q, tsh_d, crc_q, crc_d, crcp_q, crcp_d;
  logic [7:0]  cmd_q, cmd_d, last_q, last_d, tb;
  logic [15:0] dat_q, dat_d, rd_word, mode_d, rate_d, cap_al_d, time_al_d;
  logic [31:0] txt;
  logic        rd_q, rd_d, drv_q, drv_d, pw_q, pw_d, unlock_d, ack, load_ok;
  logic [15:0] mode_rd;

  // reserved and capability bits are never stored
  always_comb begin
    mode_rd = '0;
    mode_rd[MODE_INT_CHG] = HAS_INT_CHG;
    mode_rd[MODE_PRI_SUP] = HAS_PRI_SUP;
    mode_rd[MODE_COND] = meas.cond;
    mode_rd[MODE_CHG_EN] = mode_q[MODE_CHG_EN];
    mode_rd[MODE_PRIMARY] = mode_q[MODE_PRIMARY];
    mode_rd[MODE_CHG_INHIB] = mode_q[MODE_CHG_INHIB];
    mode_rd[MODE_CAP_POWER] = mode_q[MODE_CAP_POWER];
  end

  always_comb begin
    unique case (cmd_q)
      CMD_ACCESS:    rd_word = FW_VERSION;
      CMD_CAP_ALARM: rd_word = cap_alarm_q;
      CMD_TIME_ALRM: rd_word = time_alarm_q;
      CMD_MODE:      rd_word = mode_rd;
      CMD_RATE:      rd_word = rate_q;
      CMD_TT_FULL:   rd_word = meas.tt_full;
      CMD_TT_EMPTY:  rd_word = meas.tt_empty;
      // a non-negative rate never fails the load check
      CMD_RATE_OK:   rd_word = {15'h0000, ~rate_q[15] | meas.rate_ok};
      CMD_TEMP:      rd_word = meas.temp;
      CMD_VOLT:      rd_word = meas.volt;
      CMD_CURR:      rd_word = meas.curr;
      CMD_AVG_CURR:  rd_word = meas.avg_curr;
      CMD_MAX_ERR:   rd_word = meas.max_err;
      CMD_RSOC:      rd_word = meas.rsoc;
      CMD_ASOC:      rd_word = meas.asoc;
      CMD_CAP_LEFT:  rd_word = meas.cap_left;
      CMD_CAP_FULL:  rd_word = meas.cap_full;
      CMD_RUN_TTE:   rd_word = meas.run_tte;
      CMD_AVG_TTE:   rd_word = meas.avg_tte;
      CMD_AVG_TTF:   rd_word = meas.avg_ttf;
      CMD_CHG_CURR:  rd_word = meas.chg_curr;
      CMD_CHG_VOLT:  rd_word = meas.chg_volt;
      CMD_STATUS:    rd_word = meas.status;
      CMD_CYCLES:    rd_word = meas.cycles;
      CMD_DES_CAP:   rd_word = meas.des_cap;
      CMD_DES_VOLT:  rd_word = meas.des_volt;
      CMD_SPEC:      rd_word = SPEC_INFO;
      CMD_DATE:      rd_word = meas.date;
      CMD_SERIAL:    rd_word = meas.serial;
      CMD_FW_INFO:   rd_word = FW_VERSION;
      CMD_PIN_STATE: rd_word = meas.pins;
      default:       rd_word = VEND_FILL;
    endcase
    unique case (cmd_q)
      CMD_TXT_MAKER: txt = TXT_MAKER;
      CMD_TXT_PROD:  txt = TXT_PROD;
      CMD_TXT_CHEM:  txt = TXT_CHEM;
      default:       txt = MAKER_DATA;
    endcase
  end

  always_comb begin
    sst_d = sst_q; bit_d = bit_q; idx_d = idx_q; tix_d = tix_q;
    sh_d = sh_q; tsh_d = tsh_q; crc_d = crc_q; crcp_d = crcp_q;
    cmd_d = cmd_q; dat_d = dat_q; last_d = last_q; rd_d = rd_q;
    drv_d = drv_q; pw_d = pw_q; unlock_d = unlock_q; mode_d = mode_q;
    rate_d = rate_q; cap_al_d = cap_alarm_q; time_al_d = time_alarm_q;
    ack = 1'b0;
    tn = (tix_q == 3'h7) ? tix_q : tix_q + 3'h1;
    tb = tx_byte(cmd_q, 3'h0, crc_q, rd_word, txt);
    // a pec byte is optional; a wrong one drops the write
    load_ok = (idx_q == IDX_WORD) || (idx_q == IDX_WPEC && last_q == crcp_q);
    if (scl_rise) sh_d = {sh_q[6:0], sda};
    if (start) begin
      // the first fall after a start ends no bit: all ones wraps to zero there
      sst_d = SL_RX; bit_d = '1; idx_d = IDX_ADDR; drv_d = 1'b0;
    end else if (stop) begin
      if (sst_q != SL_IDLE && !rd_q && load_ok) begin
        unique case (cmd_q)
          CMD_ACCESS: begin
            pw_d = (dat_q == PW_FIRST);
            unlock_d = (pw_q && dat_q == PW_SECOND) || (unlock_q && dat_q == PW_FIRST);
          end
          CMD_CAP_ALARM: cap_al_d = dat_q;
          CMD_TIME_ALRM: time_al_d = dat_q;
          CMD_MODE: begin
            mode_d[MODE_CHG_EN] = dat_q[MODE_CHG_EN] & HAS_INT_CHG;
            mode_d[MODE_PRIMARY] = dat_q[MODE_PRIMARY] & HAS_PRI_SUP;
            mode_d[MODE_CHG_INHIB] = dat_q[MODE_CHG_INHIB];
            mode_d[MODE_CAP_POWER] = dat_q[MODE_CAP_POWER];
          end
          CMD_RATE: rate_d = dat_q;
          default: ;
        endcase
      end
      sst_d = SL_IDLE; drv_d = 1'b0; crc_d = '0; rd_d = 1'b0;
    end else if (scl_fall) begin
      unique case (sst_q)
        SL_RX: begin
          if (bit_q == BIT_ACK) begin
            drv_d = 1'b0; bit_d = '0;
            if (rd_q) begin
              sst_d = SL_TX; tix_d = '0; tsh_d = tb;
              crc_d = crc8(crc_q, tb); drv_d = ~tb[7];
            end
          end else if (bit_q == BIT_LAST) begin
            crcp_d = crc_q; crc_d = crc8(crc_q, sh_q);
            idx_d = (idx_q == IDX_WPEC) ? idx_q : idx_q + 3'h1;
            unique case (idx_q)
              IDX_ADDR: begin ack = (sh_q[7:1] == SLAVE_ADDR); rd_d = sh_q[0]; end
              IDX_CMD:  begin ack = mapped(sh_q); cmd_d = sh_q; end
              IDX_LO:   begin ack = 1'b1; dat_d[7:0] = sh_q; end
              IDX_HI:   begin ack = 1'b1; dat_d[15:8] = sh_q; end
              default:  begin ack = 1'b1; last_d = sh_q; end
            endcase
            if (ack) begin
              drv_d = 1'b1; bit_d = BIT_ACK;
            end else sst_d = SL_WAIT;
          end else bit_d = bit_q + 4'h1;
        end
        SL_TX: begin
          if (bit_q == BIT_ACK) begin
            bit_d = '0;
            if (sh_q[0]) begin
              sst_d = SL_WAIT; drv_d = 1'b0;
            end else begin
              tb = tx_byte(cmd_q, tn, crc_q, rd_word, txt);
              tix_d = tn; tsh_d = tb; crc_d = crc8(crc_q, tb); drv_d = ~tb[7];
            end
          end else if (bit_q == BIT_LAST) begin
            drv_d = 1'b0; bit_d = BIT_ACK;
          end else begin
            bit_d = bit_q + 4'h1; tsh_d = {tsh_q[6:0], 1'b0}; drv_d = ~tsh_q[6];
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      sst_q <= SL_IDLE; bit_q <= '0; idx_q <= '0; tix_q <= '0;
      sh_q <= '0; tsh_q <= '0; crc_q <= '0; crcp_q <= '0;
      cmd_q <= '0; dat_q <= '0; last_q <= '0; rd_q <= 1'b0;
      drv_q <= 1'b0; pw_q <= 1'b0; unlock_q <= 1'b0; mode_q <= MODE_RESET;
      rate_q <= REG_RESET; cap_alarm_q <= REG_RESET; time_alarm_q <= REG_RESET;
    end else begin
      sst_q <= sst_d; bit_q <= bit_d; idx_q <= idx_d; tix_q <= tix_d;
      sh_q <= sh_d; tsh_q <= tsh_d; crc_q <= crc_d; crcp_q <= crcp_d;
      cmd_q <= cmd_d; dat_q <= dat_d; last_q <= last_d; rd_q <= rd_d;
      drv_q <= drv_d; pw_q <= pw_d; unlock_q <= unlock_d; mode_q <= mode_d;
      rate_q <= rate_d; cap_alarm_q <= cap_al_d; time_alarm_q <= time_al_d;
    end
  end

  // master: word writes of charge current then voltage
  sbm_ms_t    mst_q, mst_d;
  logic [1:0] q_q, q_d, mby_q, mby_d, pend_q, pend_d;
  logic [3:0] mbit_q, mbit_d;
  logic [8:0] div_q, div_d;
  logic       msda_q, msda_d, mscl_q, mscl_d, tick;
  logic [7:0] mb;
  logic [15:0] mword;

  assign tick = (div_q == 9'(QTR_CYC - 1));

  always_comb begin
    mst_d = mst_q; q_d = q_q; mby_d = mby_q; pend_d = pend_q;
    mbit_d = mbit_q; msda_d = msda_q; mscl_d = mscl_q;
    div_d = (mst_q == M_IDLE || tick) ? '0 : div_q + 9'h001;
    mword = pend_q[0] ? meas.chg_curr : meas.chg_volt;
    unique case (mby_q)
      2'h0: mb = {CHARGE_ADDR, 1'b0};
      2'h1: mb = pend_q[0] ? CMD_CHG_CURR : CMD_CHG_VOLT;
      2'h2: mb = mword[7:0];
      2'h3: mb = mword[15:8];
    endcase
    unique case (mst_q)
      M_IDLE: if (pend_q != 2'h0 && sst_q == SL_IDLE && scl && sda) begin
        mst_d = M_START; q_d = '0; mby_d = '0; mbit_d = '0;
      end
      M_START: if (tick) begin
        q_d = q_q + 2'h1;
        if (q_q == 2'h0) msda_d = 1'b1;
        if (q_q == 2'h1) begin
          mscl_d = 1'b1; mst_d = M_BIT; q_d = '0;
        end
      end
      M_BIT: if (tick) begin
        unique case (q_q)
          2'h0: begin
            msda_d = (mbit_q == BIT_ACK) ? 1'b0 : ~mb[3'h7 - mbit_q[2:0]];
            q_d = 2'h1;
          end
          2'h1: begin mscl_d = 1'b0; q_d = 2'h2; end
          // wait here while the slave stretches the clock
          2'h2: if (scl) begin
            q_d = 2'h3;
            if (mbit_q != BIT_ACK && !msda_q && !sda) begin
              mst_d = M_IDLE; msda_d = 1'b0; mscl_d = 1'b0;
            end else if (mbit_q == BIT_ACK && sda) mby_d = 2'h3;
          end
          2'h3: begin
            mscl_d = 1'b1; q_d = 2'h0;
            if (mbit_q == BIT_ACK) begin
              mbit_d = '0;
              if (mby_q == 2'h3) mst_d = M_STOP;
              else mby_d = mby_q + 2'h1;
            end else mbit_d = mbit_q + 4'h1;
          end
        endcase
      end
      M_STOP: if (tick) begin
        q_d = q_q + 2'h1;
        unique case (q_q)
          2'h0: msda_d = 1'b1;
          2'h1: mscl_d = 1'b0;
          2'h2: if (scl) msda_d = 1'b0;
              else q_d = q_q;
          2'h3: begin
            mst_d = M_IDLE;
            pend_d = pend_q[0] ? {pend_q[1], 1'b0} : 2'h0;
          end
        endcase
      end
    endcase
    if (charge_push && !mode_q[MODE_CHG_INHIB]) pend_d = 2'h3;
    if (mode_q[MODE_CHG_INHIB]) pend_d = 2'h0;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      mst_q <= M_IDLE; q_q <= '0; mby_q <= '0; pend_q <= '0;
      mbit_q <= '0; div_q <= '0; msda_q <= 1'b0; mscl_q <= 1'b0;
      scl_o_q <= 1'b0; sda_o_q <= 1'b0; scl_oe_q <= 1'b0; sda_oe_q <= 1'b0;
    end else begin
      mst_q <= mst_d; q_q <= q_d; mby_q <= mby_d; pend_q <= pend_d;
      mbit_q <= mbit_d; div_q <= div_d; msda_q <= msda_d; mscl_q <= mscl_d;
      scl_o_q <= 1'b0; sda_o_q <= 1'b0;
      scl_oe_q <= mscl_d;
      sda_oe_q <= drv_d | msda_d;
    end
  end
endmodule

/* File: pkg/sbm_pkg.sv */
// sbm_pkg: command codes, field positions, timing and carrier types
// of the battery command map. Assumes one 100 MHz clock domain.
// Functional notes
// - code 0x1d reads version; password pair written to 0x00 unlocks storage.
// - rate query at 0x04 is a signed current or power for three predictions.
// - code 0x05 reads minutes to full at the rate query current.
// - code 0x06 reads minutes to empty at the rate query value.
// - code 0x07 reads a boolean in the lsb: ten second load capability.
// - rate query zero or positive makes the load check always true.
// - mode bit 14 set stops charging requests going to the charger.
// - mode bit 14 clear sends charging requests whenever charging is wanted.
// - mode bit 15 selects 10 mW/10 mWh units, clear selects mA/mAh.
// - code 0x08 reads pack temperature in tenths of a kelvin.
// - code 0x09 reads pack voltage in millivolts.
// - slave word and block reads and word writes, each with optional CRC-8 check.
// - as bus master only the word write protocol is used.
package sbm_pkg;
  localparam logic [7:0] CMD_ACCESS    = 8'h00;
  localparam logic [7:0] CMD_CAP_ALARM = 8'h01;
  localparam logic [7:0] CMD_TIME_ALRM = 8'h02;
  localparam logic [7:0] CMD_MODE      = 8'h03;
  localparam logic [7:0] CMD_RATE      = 8'h04;
  localparam logic [7:0] CMD_TT_FULL   = 8'h05;
  localparam logic [7:0] CMD_TT_EMPTY  = 8'h06;
  localparam logic [7:0] CMD_RATE_OK   = 8'h07;
  localparam logic [7:0] CMD_TEMP      = 8'h08;
  localparam logic [7:0] CMD_VOLT      = 8'h09;
  localparam logic [7:0] CMD_CURR      = 8'h0a;
  localparam logic [7:0] CMD_AVG_CURR  = 8'h0b;
  localparam logic [7:0] CMD_MAX_ERR   = 8'h0c;
  localparam logic [7:0] CMD_RSOC      = 8'h0d;
  localparam logic [7:0] CMD_ASOC      = 8'h0e;
  localparam logic [7:0] CMD_CAP_LEFT  = 8'h0f;
  localparam logic [7:0] CMD_CAP_FULL  = 8'h10;
  localparam logic [7:0] CMD_RUN_TTE   = 8'h11;
  localparam logic [7:0] CMD_AVG_TTE   = 8'h12;
  localparam logic [7:0] CMD_AVG_TTF   = 8'h13;
  localparam logic [7:0] CMD_CHG_CURR  = 8'h14;
  localparam logic [7:0] CMD_CHG_VOLT  = 8'h15;
  localparam logic [7:0] CMD_STATUS    = 8'h16;
  localparam logic [7:0] CMD_CYCLES    = 8'h17;
  localparam logic [7:0] CMD_DES_CAP   = 8'h18;
  localparam logic [7:0] CMD_DES_VOLT  = 8'h19;
  localparam logic [7:0] CMD_SPEC      = 8'h1a;
  localparam logic [7:0] CMD_DATE      = 8'h1b;
  localparam logic [7:0] CMD_SERIAL    = 8'h1c;
  localparam logic [7:0] CMD_FW_INFO   = 8'h1d;
  localparam logic [7:0] CMD_TXT_MAKER = 8'h20;
  localparam logic [7:0] CMD_TXT_PROD  = 8'h21;
  localparam logic [7:0] CMD_TXT_CHEM  = 8'h22;
  localparam logic [7:0] CMD_MAKER_DAT = 8'h23;
  localparam logic [7:0] CMD_PIN_STATE = 8'h2f;
  localparam logic [7:0] CMD_VEND_LO   = 8'h3c;
  localparam logic [7:0] CMD_VEND_HI   = 8'h3f;

  localparam int MODE_INT_CHG   = 0;
  localparam int MODE_PRI_SUP   = 1;
  localparam int MODE_COND      = 7;
  localparam int MODE_CHG_EN    = 8;
  localparam int MODE_PRIMARY   = 9;
  localparam int MODE_CHG_INHIB = 14;
  localparam int MODE_CAP_POWER = 15;
  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [15:0] REG_RESET  = 16'h0000;
  localparam logic [15:0] VEND_FILL  = 16'h0000;

  localparam logic [3:0] BIT_LAST  = 4'h7;
  localparam logic [3:0] BIT_ACK   = 4'h8;
  localparam logic [2:0] IDX_ADDR  = 3'h0;
  localparam logic [2:0] IDX_CMD   = 3'h1;
  localparam logic [2:0] IDX_LO    = 3'h2;
  localparam logic [2:0] IDX_HI    = 3'h3;
  localparam logic [2:0] IDX_PEC   = 3'h4;
  localparam logic [2:0] IDX_WORD  = 3'h4;
  localparam logic [2:0] IDX_WPEC  = 3'h5;
  localparam logic [7:0] TEXT_LEN  = 8'h04;
  localparam logic [7:0] CRC_POLY  = 8'h07;
  localparam logic [7:0] FILL_BYTE = 8'hff;

  localparam int CLK_KHZ = 100000;
  localparam int SMB_KHZ = 100;
  localparam int QTR_CYC = CLK_KHZ / (SMB_KHZ * 4);

  typedef struct packed {
    logic [15:0] tt_full, tt_empty, temp, volt, curr, avg_curr;
    logic [15:0] max_err, rsoc, asoc, cap_left, cap_full, run_tte;
    logic [15:0] avg_tte, avg_ttf, chg_curr, chg_volt, status;
    logic [15:0] cycles, des_cap, des_volt, date, serial, pins;
    logic        rate_ok, cond;
  } sbm_meas_t;
endpackage

/* File: testbench/sbm_cmd_map_asserts.sv */
// checker for the battery command map ports
// assumes one clock domain, bound onto every instance of the map
module sbm_cmd_map_asserts
  import sbm_pkg::*;
(
  input wire logic        clock,
  input wire logic        srst,
  input wire logic        scl_i,
  input wire logic        sda_i,
  input wire sbm_meas_t   meas,
  input wire logic        charge_push,
  input wire logic        scl_o_q,
  input wire logic        scl_oe_q,
  input wire logic        sda_o_q,
  input wire logic        sda_oe_q,
  input wire logic [15:0] mode_q,
  input wire logic [15:0] rate_q,
  input wire logic [15:0] cap_alarm_q,
  input wire logic [15:0] time_alarm_q,
  input wire logic        unlock_q
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  property p_reset_clear;
    disable iff (1'b0) srst |=> !scl_oe_q && !sda_oe_q && mode_q == 16'h0000
      && rate_q == 16'h0000 && !unlock_q;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("state not cleared by reset");
  property p_mode_resv;
    mode_q[13:10] == 4'h0;
  endproperty
  a_mode_resv: assert property (p_mode_resv)
    else $error("reserved mode bits set");
  property p_pins_od;
    !scl_o_q && !sda_o_q;
  endproperty
  a_pins_od: assert property (p_pins_od)
    else $error("pin driven high");
  property p_rate_at_stop;
    $changed(rate_q) |-> scl_i && sda_i;
  endproperty
  a_rate_at_stop: assert property (p_rate_at_stop)
    else $error("rate changed outside stop");
  property p_regs_at_stop;
    $changed({cap_alarm_q, time_alarm_q, mode_q}) |-> scl_i && sda_i;
  endproperty
  a_regs_at_stop: assert property (p_regs_at_stop)
    else $error("register changed outside stop");
  property p_unlock_at_stop;
    $changed(unlock_q) |-> scl_i && sda_i;
  endproperty
  a_unlock_at_stop: assert property (p_unlock_at_stop)
    else $error("unlock changed outside stop");
  // a start by the map is the only sda pull while scl is high
  property p_no_push_inhib;
    $rose(sda_oe_q) && scl_i |-> !mode_q[14];
  endproperty
  a_no_push_inhib: assert property (p_no_push_inhib)
    else $error("charging push while inhibited");
  property p_push_go;
    charge_push && !mode_q[14] && scl_i && sda_i && !sda_oe_q
      |-> ##[1:1000] ($rose(sda_oe_q) && scl_i);
  endproperty
  a_push_go: assert property (p_push_go)
    else $error("charging push not started");
  property p_scl_low_hold;
    $rose(scl_oe_q) |=> scl_oe_q [*8];
  endproperty
  a_scl_low_hold: assert property (p_scl_low_hold)
    else $error("master clock low too short");
endmodule

bind sbm_cmd_map sbm_cmd_map_asserts u_chk (
  .clock(clock), .srst(srst), .scl_i(scl_i), .sda_i(sda_i), .meas(meas),
  .charge_push(charge_push), .scl_o_q(scl_o_q), .scl_oe_q(scl_oe_q),
  .sda_o_q(sda_o_q), .sda_oe_q(sda_oe_q), .mode_q(mode_q), .rate_q(rate_q),
  .cap_alarm_q(cap_alarm_q), .time_alarm_q(time_alarm_q), .unlock_q(unlock_q)
);

/* File: testbench/sbm_charger_model.sv */
// charger side: word-write slave at address 0x09, keeps two messages
// assumes resolved wires and the bench clock for sampling
module sbm_charger_model (
  input  wire logic   clock,
  input  wire logic   scl,
  input  wire logic   sda,
  output logic        sda_oe,
  output int          n_msg,
  output logic [23:0] m0,
  output logic [23:0] m1
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        scl_p = 1'b1, sda_p = 1'b1, mine = 1'b0;
  logic [3:0]  nb = 4'h0;
  logic [7:0]  sh = 8'h00;
  logic [23:0] bf = 24'h000000;
  int          idx = 0;
  initial begin
    sda_oe = 1'b0;
    n_msg = 0;
    m0 = 24'h000000;
    m1 = 24'h000000;
  end
  always @(posedge clock) begin
    scl_p <= scl;
    sda_p <= sda;
    if (scl && scl_p && sda_p && !sda) begin
      nb <= 4'h0;
      idx <= 0;
    end else if (scl && scl_p && !sda_p && sda) begin
      // only a plain word write counts; a read or extra byte is lost
      if (mine && idx == 4) begin
        if (n_msg == 0) m0 <= bf;
        else m1 <= bf;
        n_msg <= n_msg + 1;
      end
      idx <= 0;
      mine <= 1'b0;
    end else if (scl && !scl_p) begin
      sh <= {sh[6:0], sda};
      nb <= nb + 4'h1;
    end else if (!scl && scl_p && nb == 4'h8) begin
      if (idx == 0) mine <= sh == 8'h12;
      sda_oe <= idx == 0 ? sh == 8'h12 : mine;
      bf <= {bf[15:0], sh};
      idx <= idx + 1;
    end else if (!scl && scl_p && nb == 4'h9) begin
      sda_oe <= 1'b0;
      nb <= 4'h0;
    end
  end
endmodule

/* File: testbench/tb.sv */
// bench: bit-banged two-wire host driving the command map
// assumes pull-ups on both wires, charger model on the same wires
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import sbm_pkg::*;
  logic clock = 0, srst = 1, push = 0, t_scl = 0, t_sda = 0, unl;
  logic scl_oe, sda_oe, c_oe, scl, sda;
  logic [15:0] mode, rate, cap, tim;
  logic [23:0] m0, m1;
  logic [39:0] d;
  // pec runs across a repeated start, cleared only by a stop
  logic [7:0] crc = 8'h00;
  sbm_meas_t meas = '0;
  int n_errors = 0, checks = 0, n_msg;
  assign scl = !(scl_oe | t_scl);
  assign sda = !(sda_oe | t_sda | c_oe);
  always #5 clock = !clock;
  sbm_cmd_map dut (.clock(clock), .srst(srst), .scl_i(scl), .sda_i(sda), .meas(meas),
    .charge_push(push), .scl_o_q(), .scl_oe_q(scl_oe), .sda_o_q(), .sda_oe_q(sda_oe),
    .mode_q(mode), .rate_q(rate), .cap_alarm_q(cap), .time_alarm_q(tim), .unlock_q(unl));
  sbm_charger_model chg (.clock(clock), .scl(scl), .sda(sda), .sda_oe(c_oe),
    .n_msg(n_msg), .m0(m0), .m1(m1));
  task automatic clk(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic chk(logic [39:0] g, logic [39:0] e);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  function automatic logic [7:0] cr(logic [7:0] c, logic [7:0] b);
    c ^= b;
    repeat (8) c = c[7] ? {c[6:0], 1'b0} ^ CRC_POLY : {c[6:0], 1'b0};
    return c;
  endfunction
  // sda only moves two clocks after scl falls, never beside an edge
  task automatic bitx(logic b, output logic r);
    t_scl = 1;
    clk(2);
    t_sda = !b;
    clk(6);
    t_scl = 0;
    clk(4);
    r = sda;
  endtask
  task automatic st;
    t_scl = 1;
    clk(2);
    t_sda = 0;
    clk(6);
    t_scl = 0;
    clk(4);
    t_sda = 1;
    clk(4);
  endtask
  task automatic sp;
    t_scl = 1;
    clk(2);
    t_sda = 1;
    clk(6);
    t_scl = 0;
    clk(4);
    t_sda = 0;
    clk(20);
    crc = 8'h00;
  endtask
  task automatic xb(logic [7:0] b, logic m, output logic [7:0] r, output logic k);
    for (int i = 7; i >= 0; i--) bitx(b[i], r[i]);
    bitx(m, k);
  endtask
  task automatic sb(logic [7:0] b, logic e);
    logic [7:0] r;
    logic k;
    xb(b, 1'b1, r, k);
    crc = cr(crc, b);
    chk(k, e);
  endtask
  task automatic wr(logic [7:0] c, logic [15:0] w, int p);
    st;
    sb(8'h16, 0);
    sb(c, 0);
    sb(w[7:0], 0);
    sb(w[15:8], 0);
    if (p != 0) sb(crc ^ 8'(p == 2), 0);
    sp;
  endtask
  task automatic rd(logic [7:0] c, int n);
    logic [7:0] r;
    logic k;
    st;
    sb(8'h16, 0);
    sb(c, 0);
    st;
    sb(8'h17, 0);
    d = '0;
    for (int i = 0; i < n; i++) begin
      xb(8'hff, 1'b0, r, k);
      crc = cr(crc, r);
      d = {d[31:0], r};
    end
    xb(8'hff, 1'b1, r, k);
    chk(r, crc);
    sp;
  endtask
  task automatic rw(logic [7:0] c, logic [15:0] e);
    rd(c, 2);
    chk({d[7:0], d[15:8]}, e);
  endtask
  task automatic summarize;
    if (n_errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    clk(6);
    srst = 0;
    clk(4);
    chk({mode, rate, cap, unl}, 0);
    meas.cond = 1;
    meas.tt_full = 16'h0105;
    meas.tt_empty = 16'h0206;
    meas.temp = 16'h0b80;
    meas.volt = 16'h3039;
    meas.chg_curr = 16'h0bb8;
    meas.chg_volt = 16'h3a98;
    wr(CMD_RATE, 16'h0005, 0);
    rw(CMD_RATE_OK, 16'h0001);
    wr(CMD_RATE, 16'h8001, 1);
    rw(CMD_RATE_OK, 16'h0000);
    chk(rate, 16'h8001);
    rw(CMD_TT_FULL, 16'h0105);
    rw(CMD_TT_EMPTY, 16'h0206);
    meas.rate_ok = 1;
    rw(CMD_RATE_OK, 16'h0001);
    rw(CMD_RATE, 16'h8001);
    rw(CMD_TEMP, 16'h0b80);
    rw(CMD_VOLT, 16'h3039);
    wr(CMD_MODE, 16'hffff, 0);
    rw(CMD_MODE, 16'hc080);
    chk(mode, 16'hc000);
    wr(CMD_CAP_ALARM, 16'h1234, 1);
    wr(CMD_CAP_ALARM, 16'h5555, 2);
    chk(cap, 16'h1234);
    wr(CMD_TIME_ALRM, 16'h0a0b, 0);
    rw(CMD_TIME_ALRM, 16'h0a0b);
    chk(tim, 16'h0a0b);
    rd(CMD_TXT_CHEM, 5);
    chk(d, {TEXT_LEN, 32'h4e694d48});
    st;
    sb(8'h16, 0);
    sb(8'h30, 1);
    sp;
    rw(CMD_FW_INFO, 16'h0001);
    rw(CMD_ACCESS, 16'h0001);
    wr(CMD_ACCESS, 16'h1234, 0);
    wr(CMD_ACCESS, 16'h5678, 0);
    chk(unl, 1);
    wr(CMD_ACCESS, 16'h0000, 0);
    chk(unl, 0);
    push = 1;
    clk(1);
    push = 0;
    clk(3000);
    chk(n_msg, 0);
    wr(CMD_MODE, 16'h0000, 0);
    push = 1;
    clk(1);
    push = 0;
    for (int i = 0; i < 90000 && n_msg < 2; i++) clk(1);
    chk(n_msg, 2);
    chk(m0, {CMD_CHG_CURR, 16'hb80b});
    chk(m1, {CMD_CHG_VOLT, 16'h983a});
    summarize;
  end
endmodule
